// ===== dv/sllc_ctrl_bench.sv
// Self-checking bench for the link control block
`timescale 1ns/1ns
module sllc_ctrl_bench;
  logic clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, resync = 0;
  logic cd_n = 1, sysref = 0, force_en = 0, m6 = 0, ab_n, awr, wrdy, bv, arr, rv;
  logic k3, k7, dflip, m6a, mclr, sreq;
  logic [11:0] awa = '0, ara = '0;
  logic [7:0] wd = '0;
  logic [4:0] cinit = '0, cnt;
  logic [3:0] lag = '0, src;
  logic [1:0] bresp, rresp, lane;
  logic [31:0] rdata;
  logic [5:0] frames;
  logic [33:0] exp_q [$];
  int num_errors = 0, compares = 0, cyc = 0, pulses = 0;
  logic [31:0] seed = 32'hB8F1501A;
  logic [11:0] adr [3] = '{sllc_pkg::ADDR_FRAMING, sllc_pkg::ADDR_SYNC_LANE, 12'h008};
  logic [7:0] msk [3] = '{sllc_pkg::MASK_FRAMING, sllc_pkg::MASK_SYNC_LANE, 8'hF8};
  logic [3:0] pat [5] = '{4'h0, 4'h2, 4'h1, 4'h4, 4'h3};

  sllc_ctrl dut_u (.i_clk(clk), .i_sys_rst(rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata({24'h0, wd}), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(bresp), .o_bvalid(bv), .i_bready(bre), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rre),
    .i_sync_in_pair_ab_n(ab_n), .i_sync_in_pair_cd_n(cd_n), .i_sysref(sysref),
    .i_force_count_en(force_en), .i_count_init(cinit), .i_decim_mode6_enable_first(m6),
    .o_stream_src(src), .o_insert_k28_3(k3), .o_insert_k28_7(k7), .o_disp_flip(dflip),
    .o_lane_mode(lane), .o_decim_mode6_active(m6a), .o_frames_per_mf(frames),
    .o_mf_mask_clear(mclr), .o_mf_count(cnt), .o_sync_req(sreq));
  sllc_rx_model rx_u (.i_clk(clk), .i_sys_rst(rst), .i_resync(resync), .i_lag(lag),
    .i_stream_src(src), .o_sync_n(ab_n));

  always #50 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("mismatch at %0t: saw %h, wanted %h", $time, seen, want);
    end
  endtask

  task automatic test_done;
    $display("compares %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= seed[1];
    do begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv === 1'b1 && !bre) bre <= 1'b1;
    end while (!(bv === 1'b1 && bre));
    check(bresp, er);
    bre <= 1'b0;
  endtask

  // Write, then let the registered controls follow
  task automatic wrs(input logic [11:0] a, input logic [7:0] d);
    wr(a, d, sllc_pkg::RESP_OKAY);
    repeat (2) @(posedge clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] ev, input logic [1:0] er);
    @(posedge clk);
    exp_q.push_back({er, 24'h0, ev});
    ara <= a;
    arv <= 1'b1;
    rre <= seed[0];
    do begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv === 1'b1 && !rre) rre <= 1'b1;
    end while (!(rv === 1'b1 && rre));
    rre <= 1'b0;
  endtask

  // Resync through the far end; CD held low to show it is ignored
  task automatic link_run(input logic sup, input logic [3:0] lg);
    logic ila;
    wrs(sllc_pkg::ADDR_FRAMING, {7'h0, sup});
    lag <= lg;
    resync <= 1'b1;
    cd_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(sreq, 1'b1);
    check(src, sllc_pkg::SRC_K28_5);
    resync <= 1'b0;
    ila = 1'b0;
    for (int n = 0; n < 6000 && src !== sllc_pkg::SRC_SAMPLE; n++) begin
      @(posedge clk);
      if (src === sllc_pkg::SRC_ILA_LOOP) ila = 1'b1;
    end
    check(ila, !sup);
    check(src, sllc_pkg::SRC_SAMPLE);
    cd_n <= 1'b1;
    $display("test done: link start, suppress %0d", sup);
  endtask

  // Reads are compared as their answers appear; sysref and count seed are random
  always @(posedge clk) begin
    cyc++;
    seed <= lfsr(seed);
    sysref <= !rst && seed[7:0] == 8'h00;
    force_en <= seed[8];
    cinit <= seed[13:9];
    if (mclr === 1'b1) pulses++;
    if (rre && rv === 1'b1 && exp_q.size() > 0) check({rresp, rdata}, exp_q.pop_front());
    if (cyc == 40000) begin
      num_errors++;
      test_done();
    end
  end

  initial begin
    logic [7:0] d, e, fr;
    logic [1:0] ln;
    int n;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rd(adr[i], 8'h00, sllc_pkg::RESP_OKAY);
    rd(12'h00C, 8'h00, sllc_pkg::RESP_SLVERR);
    wr(12'h00C, 8'hFF, sllc_pkg::RESP_SLVERR);
    check(frames, 6'd5);
    for (int i = 0; i < 3; i++) begin
      d = seed[7:0];
      e = d & msk[i];
      if (i == 1 && fr[6]) e[1:0] = d[1:0];
      if (i == 0) fr = d;
      if (i == 1) ln = e[1:0];
      wrs(adr[i], d);
      rd(adr[i], e, sllc_pkg::RESP_OKAY);
    end
    $display("test done: reset values and readback");
    wrs(sllc_pkg::ADDR_FRAMING, 8'h00);
    wrs(sllc_pkg::ADDR_SYNC_LANE, 8'h03);
    check(lane, ln);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h40);
    for (int m = 1; m < 4; m++) begin
      wrs(sllc_pkg::ADDR_SYNC_LANE, 8'(m));
      check(lane, m[1:0]);
    end
    wrs(sllc_pkg::ADDR_FRAMING, 8'h20);
    wrs(sllc_pkg::ADDR_SYNC_LANE, 8'h08);
    m6 <= 1'b1;
    repeat (2) @(posedge clk);
    check(m6a, 1'b1);
    m6 <= 1'b0;
    repeat (2) @(posedge clk);
    check(m6a, 1'b0);
    $display("test done: lane mode and mode six");
    wrs(sllc_pkg::ADDR_TEST_PAT, 8'h00);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h04);
    check({k3, k7, src}, 6'h20);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h02);
    check({k3, k7, src}, 6'h10);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h10);
    check({k3, k7, src}, 6'h05);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h00);
    for (int p = 0; p < 5; p++) begin
      wrs(sllc_pkg::ADDR_TEST_PAT, {p[2:0], 5'h10});
      check({dflip, src}, {p == 4, pat[p]});
    end
    for (int i = 0; i < 3; i++) begin
      wrs(sllc_pkg::ADDR_SYNC_LANE, 8'h40 << (i == 1) | (i == 0 ? 8'h80 : 8'h00));
      check(src, i == 0 ? sllc_pkg::SRC_K28_5 : sllc_pkg::SRC_RPAT);
    end
    $display("test done: inserted characters and patterns");
    n = pulses;
    wrs(sllc_pkg::ADDR_TEST_PAT, 8'h08);
    wrs(sllc_pkg::ADDR_TEST_PAT, 8'h08);
    check(34'(pulses - n), 34'd2);
    rd(sllc_pkg::ADDR_TEST_PAT, 8'h08, sllc_pkg::RESP_OKAY);
    wrs(sllc_pkg::ADDR_SYNC_LANE, 8'h00);
    wrs(sllc_pkg::ADDR_FRAMES_K, 8'h0F);
    check(frames, 6'd5);
    wrs(sllc_pkg::ADDR_FRAMING, 8'h80);
    check(frames, 6'd16);
    wrs(sllc_pkg::ADDR_FRAMES_K, 8'h1F);
    check(frames, 6'd32);
    $display("test done: mask clear and multiframe length");
    link_run(1'b0, 4'h0);
    link_run(1'b1, 4'h7);
    wrs(sllc_pkg::ADDR_SYNC_LANE, 8'h20);
    cd_n <= 1'b0;
    repeat (3) @(posedge clk);
    check(sreq, 1'b1);
    cd_n <= 1'b1;
    repeat (3) @(posedge clk);
    check(sreq, 1'b0);
    lag <= 4'h0;
    resync <= 1'b1;
    repeat (3) @(posedge clk);
    check(sreq, 1'b0);
    resync <= 1'b0;
    $display("test done: sync input select");
    test_done();
  end
endmodule // sllc_ctrl_bench

// ===== dv/sllc_ctrl_checker.sv
// Port-level checks for the link control block
`timescale 1ns/1ns
module sllc_ctrl_checker (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Bus and link inputs
  input wire logic i_awvalid,
  input wire logic i_wvalid,
  input wire logic i_bready,
  input wire logic i_arvalid,
  input wire logic i_rready,
  input wire logic i_sync_in_pair_ab_n,
  input wire logic i_sync_in_pair_cd_n,
  input wire logic i_sysref,
  input wire logic i_force_count_en,
  input wire logic [4:0] i_count_init,
  // Outputs watched
  input wire logic o_awready,
  input wire logic o_wready,
  input wire logic o_bvalid,
  input wire logic o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic o_rvalid,
  input wire logic o_mf_mask_clear,
  input wire logic [4:0] o_mf_count,
  input wire logic o_sync_req
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_b_hold; o_bvalid && !i_bready |=> o_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer not held");
  property p_wr_ans; i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid; endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer late");
  property p_rd_ans; i_arvalid && o_arready |=> o_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_busy; (o_bvalid -> !o_awready) && (o_rvalid -> !o_arready); endproperty
  a_busy: assert property (p_busy) else $error("ready while answer pending");
  property p_sync_lo; !i_sync_in_pair_ab_n && !i_sync_in_pair_cd_n |=> o_sync_req; endproperty
  a_sync_lo: assert property (p_sync_lo) else $error("sync request missed");
  property p_sync_hi; i_sync_in_pair_ab_n && i_sync_in_pair_cd_n |=> !o_sync_req; endproperty
  a_sync_hi: assert property (p_sync_hi) else $error("sync request stuck");
  property p_clr; o_mf_mask_clear |=> !o_mf_mask_clear; endproperty
  a_clr: assert property (p_clr) else $error("mask clear not a pulse");
  property p_sysref;
    i_sysref |=> o_mf_count == ($past(i_force_count_en) ? $past(i_count_init) : 5'h00);
  endproperty
  a_sysref: assert property (p_sysref) else $error("count not restarted");
endmodule // sllc_ctrl_checker

bind sllc_ctrl sllc_ctrl_checker chk_u (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_awvalid(i_awvalid), .i_wvalid(i_wvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
  .i_rready(i_rready), .i_sync_in_pair_ab_n(i_sync_in_pair_ab_n),
  .i_sync_in_pair_cd_n(i_sync_in_pair_cd_n), .i_sysref(i_sysref),
  .i_force_count_en(i_force_count_en), .i_count_init(i_count_init), .o_awready(o_awready),
  .o_wready(o_wready), .o_bvalid(o_bvalid), .o_arready(o_arready), .o_rdata(o_rdata),
  .o_rvalid(o_rvalid), .o_mf_mask_clear(o_mf_mask_clear), .o_mf_count(o_mf_count),
  .o_sync_req(o_sync_req));

// ===== dv/sllc_rx_model.sv
// Far-end receiver model: holds its sync request until it has seen i_lag cycles of K28.5
`timescale 1ns/1ns
module sllc_rx_model (
  // Clock, reset and bench commands
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_resync,
  input wire logic [3:0] i_lag,
  // Lane stream seen by the receiver
  input wire logic [3:0] i_stream_src,
  // Active-low sync request back to the block
  output logic o_sync_n
);
  logic [3:0] seen_q;
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) seen_q <= 4'hF;
    else if (i_resync) seen_q <= 4'h0;
    else if (i_stream_src == sllc_pkg::SRC_K28_5 && seen_q < i_lag) seen_q <= seen_q + 4'h1;
  end
  // Large lag keeps the block in the comma state longer
  assign o_sync_n = !i_resync && seen_q >= i_lag;
endmodule // sllc_rx_model

// ===== hdl/sllc_ctrl.sv
// Link layer control registers and link start sequencing
// Behaviour
// RL1 - Override clear gives five frames per multiframe
// RL2 - Lane mode written only while change enabled
// RL3 - Software enables lane change for modes two, four
// RL4 - Software sets all three mode-six enables together
// RL5 - Transport test replaces samples with long pattern
// RL6 - Lane alignment bit inserts K28.3 characters
// RL7 - Frame alignment bit inserts K28.7 characters
// RL8 - Suppress bit skips alignment sequence after sync
// RL9 - Sync override plus request forces K28.5 data
// RL10 - Select bit picks AB or CD sync input
// RL11 - Lane mode codes 20x, 40x, 80x; 00 unused
// RL12 - Software matches PLL mode to lane mode
// RL13 - Test pattern field selects jitter patterns
// RL14 - Code 011 repeats alignment sequence continuously
// RL15 - Disparity flip acts only with RPAT selected
// RL16 - Writing one clears the multiframe clock mask
// RL17 - Software writes zero to reserved bits
// RL18 - All three control registers reset to zero
// RL19 - Sysref resets count; K28.5 stops at 31
// RL20 - Programmed multiframe length is value plus one
// RL21 - Reserved bits read back as zero
`timescale 1ns/1ns
module sllc_ctrl (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // AXI4-Lite write address
  input wire logic [11:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  // AXI4-Lite write data
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  // AXI4-Lite write response
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  // AXI4-Lite read
  input wire logic [11:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // Link side
  input wire logic i_sync_in_pair_ab_n,
  input wire logic i_sync_in_pair_cd_n,
  input wire logic i_sysref,
  input wire logic i_force_count_en,
  input wire logic [4:0] i_count_init,
  input wire logic i_decim_mode6_enable_first,
  // Controls to the lane datapath
  output logic [3:0] o_stream_src,
  output logic o_insert_k28_3,
  output logic o_insert_k28_7,
  output logic o_disp_flip,
  output logic [1:0] o_lane_mode,
  output logic o_decim_mode6_active,
  output logic [5:0] o_frames_per_mf,
  output logic o_mf_mask_clear,
  output logic [4:0] o_mf_count,
  output logic o_sync_req
);
  logic [7:0] framing_q;
  logic [7:0] sync_lane_q;
  logic [7:0] test_pat_q;
  logic [4:0] frames_k_q;
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [4:0] mf_count_q;
  logic [5:0] frame_cnt_q;
  logic sync_sel_n;
  logic [7:0] sync_merged;
  sllc_pkg::sllc_link_e link_q;

  function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                            input logic en, input logic [7:0] mask);
    merge_byte = en ? (new_v & mask) : old_v;
  endfunction

  // Address and data may arrive in either order
  assign do_write = aw_held_q && w_held_q && !o_bvalid;
  assign sync_merged = merge_byte(sync_lane_q, wdata_q[7:0], wstrb_q[0],
                                  sllc_pkg::MASK_SYNC_LANE);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      aw_held_q <= 1'b0;
      awaddr_q <= 12'h000;
    end else if (i_awvalid && o_awready) begin
      aw_held_q <= 1'b1;
      awaddr_q <= i_awaddr;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      w_held_q <= 1'b1;
      wdata_q <= i_wdata;
      wstrb_q <= i_wstrb;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  // Readies registered from next held and response state, same timing as a gate
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_awready <= 1'b1;
      o_wready <= 1'b1;
    end else begin
      o_awready <= !do_write && !(o_bvalid && !i_bready) && !aw_held_q &&
                   !(i_awvalid && o_awready);
      o_wready <= !do_write && !(o_bvalid && !i_bready) && !w_held_q &&
                  !(i_wvalid && o_wready);
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= sllc_pkg::RESP_OKAY;
    end else if (do_write) begin
      o_bvalid <= 1'b1;
      o_bresp <= (awaddr_q == sllc_pkg::ADDR_FRAMING || awaddr_q == sllc_pkg::ADDR_SYNC_LANE ||
                  awaddr_q == sllc_pkg::ADDR_TEST_PAT || awaddr_q == sllc_pkg::ADDR_FRAMES_K) ?
                 sllc_pkg::RESP_OKAY : sllc_pkg::RESP_SLVERR;
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Registers clear to zero at reset
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      framing_q <= sllc_pkg::RST_REG; // RL18
      sync_lane_q <= sllc_pkg::RST_REG; // RL18
      test_pat_q <= sllc_pkg::RST_REG; // RL18
      frames_k_q <= sllc_pkg::RST_FRAMES_K;
    end else if (do_write) begin
      case (awaddr_q)
        sllc_pkg::ADDR_FRAMING:
          framing_q <= merge_byte(framing_q, wdata_q[7:0], wstrb_q[0],
                                  sllc_pkg::MASK_FRAMING); // RL21
        sllc_pkg::ADDR_SYNC_LANE: begin
          sync_lane_q[7:2] <= sync_merged[7:2]; // RL21
          // Lane mode only moves while the change enable is set
          if (wstrb_q[0] && framing_q[sllc_pkg::B_LANE_CHG_EN]) begin
            sync_lane_q[1:0] <= wdata_q[1:0]; // RL2
          end
        end
        sllc_pkg::ADDR_TEST_PAT:
          test_pat_q <= merge_byte(test_pat_q, wdata_q[7:0], wstrb_q[0],
                                   sllc_pkg::MASK_TEST_PAT); // RL21
        sllc_pkg::ADDR_FRAMES_K:
          if (wstrb_q[0]) begin
            frames_k_q <= wdata_q[4:0];
          end
        default: begin
        end
      endcase
    end
  end

  // Mask clear is a one-cycle pulse per write of one; stored bit reads back
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_mf_mask_clear <= 1'b0;
    end else begin
      o_mf_mask_clear <= do_write && awaddr_q == sllc_pkg::ADDR_TEST_PAT && wstrb_q[0] &&
                         wdata_q[sllc_pkg::B_MASK_CLEAR]; // RL16
    end
  end

  // Read channel: one read at a time, answer one cycle after address
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
      o_rdata <= 32'h0000_0000;
      o_rresp <= sllc_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_rvalid <= 1'b1;
      o_arready <= 1'b0;
      o_rresp <= sllc_pkg::RESP_OKAY;
      case (i_araddr)
        sllc_pkg::ADDR_FRAMING: o_rdata <= {24'h000000, framing_q};
        sllc_pkg::ADDR_SYNC_LANE: o_rdata <= {24'h000000, sync_lane_q};
        sllc_pkg::ADDR_TEST_PAT: o_rdata <= {24'h000000, test_pat_q};
        sllc_pkg::ADDR_FRAMES_K: o_rdata <= {27'h0000000, frames_k_q};
        sllc_pkg::ADDR_STATUS: o_rdata <= {20'h00000, link_q, 3'h0, mf_count_q};
        default: begin
          o_rdata <= 32'h0000_0000;
          o_rresp <= sllc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Sync select picks which request pin drives the link
  assign sync_sel_n = sync_lane_q[sllc_pkg::B_SYNC_SEL] ?
                      i_sync_in_pair_cd_n : i_sync_in_pair_ab_n; // RL10

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_sync_req <= 1'b0;
    end else begin
      o_sync_req <= !sync_sel_n;
    end
  end

  // Frames per multiframe
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_frames_per_mf <= sllc_pkg::FRAMES_DEFAULT;
    end else if (framing_q[sllc_pkg::B_MF_OVERRIDE]) begin
      o_frames_per_mf <= {1'b0, frames_k_q} + 6'd1; // RL20
    end else begin
      o_frames_per_mf <= sllc_pkg::FRAMES_DEFAULT; // RL1
    end
  end

  // Multiframe counter, restarted by sysref
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mf_count_q <= 5'h00;
      frame_cnt_q <= 6'h00;
    end else if (i_sysref) begin
      mf_count_q <= i_force_count_en ? i_count_init : 5'h00; // RL19
      frame_cnt_q <= 6'h00;
    end else if (frame_cnt_q + 6'd1 >= o_frames_per_mf) begin
      frame_cnt_q <= 6'h00;
      mf_count_q <= mf_count_q + 5'd1;
    end else begin
      frame_cnt_q <= frame_cnt_q + 6'd1;
    end
  end

  // Link start: K28.5 while sync asserted, then ILA unless suppressed
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      link_q <= sllc_pkg::SLLC_MF_IDLE;
    end else if (!sync_sel_n) begin
      link_q <= sllc_pkg::SLLC_MF_K28;
    end else begin
      case (link_q)
        sllc_pkg::SLLC_MF_IDLE: link_q <= sllc_pkg::SLLC_MF_DATA;
        sllc_pkg::SLLC_MF_K28:
          // K28.5 runs on until the multiframe count reaches its end
          if (mf_count_q == sllc_pkg::MF_COUNT_END) begin // RL19
            link_q <= framing_q[sllc_pkg::B_LINK_SUPPRESS] ?
                      sllc_pkg::SLLC_MF_DATA : sllc_pkg::SLLC_MF_ILA; // RL8
          end
        sllc_pkg::SLLC_MF_ILA:
          if (mf_count_q == sllc_pkg::MF_COUNT_END) begin
            link_q <= sllc_pkg::SLLC_MF_DATA;
          end
        sllc_pkg::SLLC_MF_DATA: link_q <= sllc_pkg::SLLC_MF_DATA;
        default: link_q <= sllc_pkg::SLLC_MF_IDLE;
      endcase
    end
  end

  // Stream source priority: link start, software sync, test patterns, data
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_stream_src <= sllc_pkg::SRC_SAMPLE;
    end else if (link_q == sllc_pkg::SLLC_MF_K28) begin
      o_stream_src <= sllc_pkg::SRC_K28_5;
    end else if (link_q == sllc_pkg::SLLC_MF_ILA) begin
      o_stream_src <= sllc_pkg::SRC_ILA_LOOP; // RL8
    end else if (sync_lane_q[sllc_pkg::B_SW_SYNC_EN] && sync_lane_q[sllc_pkg::B_SW_SYNC_REQ]) begin
      o_stream_src <= sllc_pkg::SRC_K28_5; // RL9
    end else begin
      case (test_pat_q[7:5]) // RL13
        sllc_pkg::TP_D21_5: o_stream_src <= sllc_pkg::SRC_D21_5;
        sllc_pkg::TP_K28_5: o_stream_src <= sllc_pkg::SRC_K28_5;
        sllc_pkg::TP_ILA_LOOP: o_stream_src <= sllc_pkg::SRC_ILA_LOOP; // RL14
        sllc_pkg::TP_RPAT: o_stream_src <= sllc_pkg::SRC_RPAT;
        default: o_stream_src <= framing_q[sllc_pkg::B_TRANSPORT_TEST] ?
                                 sllc_pkg::SRC_TRANSPORT : sllc_pkg::SRC_SAMPLE; // RL5
      endcase
    end
  end

  // Static controls to the lane datapath
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_insert_k28_3 <= 1'b0;
      o_insert_k28_7 <= 1'b0;
      o_disp_flip <= 1'b0;
      o_lane_mode <= sllc_pkg::LM_UNUSED;
      o_decim_mode6_active <= 1'b0;
    end else begin
      o_insert_k28_3 <= framing_q[sllc_pkg::B_LANE_ALIGN]; // RL6
      o_insert_k28_7 <= framing_q[sllc_pkg::B_FRAME_ALIGN]; // RL7
      o_disp_flip <= test_pat_q[sllc_pkg::B_DISP_FLIP] &&
                     test_pat_q[7:5] == sllc_pkg::TP_RPAT; // RL15
      o_lane_mode <= sync_lane_q[1:0]; // RL11
      // Mode six only works with the first-enable input and both software enable bits set
      o_decim_mode6_active <= i_decim_mode6_enable_first && framing_q[sllc_pkg::B_MODE6_EN2] &&
                              sync_lane_q[sllc_pkg::B_MODE6_EN3]; // RL4
    end
  end

  assign o_mf_count = mf_count_q;
endmodule // sllc_ctrl

// ===== hdl/sllc_pkg.sv
// Package for the serial link layer control block: offsets, fields, codes
package sllc_pkg;
  // Register byte addresses (printed offsets 0h, 1h, 2h are kept as indices)
  localparam logic [1:0] REG_IDX_FRAMING = 2'h0;
  localparam logic [1:0] REG_IDX_SYNC_LANE = 2'h1;
  localparam logic [1:0] REG_IDX_TEST_PAT = 2'h2;
  localparam logic [3:0] REG_IDX_FRAMES_K = 4'h6;
  localparam logic [3:0] REG_IDX_STATUS = 4'h8;
  localparam logic [11:0] ADDR_FRAMING = 12'h000;
  localparam logic [11:0] ADDR_SYNC_LANE = 12'h004;
  localparam logic [11:0] ADDR_TEST_PAT = 12'h008;
  localparam logic [11:0] ADDR_FRAMES_K = 12'h018;
  localparam logic [11:0] ADDR_STATUS = 12'h020;
  // Reset values
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [4:0] RST_FRAMES_K = 5'h00;
  // Writable bit masks; reserved bits read zero
  localparam logic [7:0] MASK_FRAMING = 8'hF7;
  localparam logic [7:0] MASK_SYNC_LANE = 8'hE8;
  localparam logic [7:0] MASK_TEST_PAT = 8'hF8;
  // Field positions, framing register
  localparam int B_MF_OVERRIDE = 7;
  localparam int B_LANE_CHG_EN = 6;
  localparam int B_MODE6_EN2 = 5;
  localparam int B_TRANSPORT_TEST = 4;
  localparam int B_LANE_ALIGN = 2;
  localparam int B_FRAME_ALIGN = 1;
  localparam int B_LINK_SUPPRESS = 0;
  // Field positions, sync/lane register
  localparam int B_SW_SYNC_REQ = 7;
  localparam int B_SW_SYNC_EN = 6;
  localparam int B_SYNC_SEL = 5;
  localparam int B_MODE6_EN3 = 3;
  // Field positions, test pattern register
  localparam int B_DISP_FLIP = 4;
  localparam int B_MASK_CLEAR = 3;
  // Multiframe
  localparam logic [5:0] FRAMES_DEFAULT = 6'd5;
  localparam logic [4:0] MF_COUNT_END = 5'd31;
  // Lane modes
  localparam logic [1:0] LM_UNUSED = 2'b00;
  localparam logic [1:0] LM_20X = 2'b01;
  localparam logic [1:0] LM_40X = 2'b10;
  localparam logic [1:0] LM_80X = 2'b11;
  // Link test pattern codes
  localparam logic [2:0] TP_NORMAL = 3'b000;
  localparam logic [2:0] TP_D21_5 = 3'b001;
  localparam logic [2:0] TP_K28_5 = 3'b010;
  localparam logic [2:0] TP_ILA_LOOP = 3'b011;
  localparam logic [2:0] TP_RPAT = 3'b100;
  // Stream source select codes
  localparam logic [3:0] SRC_SAMPLE = 4'h0;
  localparam logic [3:0] SRC_K28_5 = 4'h1;
  localparam logic [3:0] SRC_D21_5 = 4'h2;
  localparam logic [3:0] SRC_RPAT = 4'h3;
  localparam logic [3:0] SRC_ILA_LOOP = 4'h4;
  localparam logic [3:0] SRC_TRANSPORT = 4'h5;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    SLLC_MF_IDLE = 4'b0001,
    SLLC_MF_K28 = 4'b0010,
    SLLC_MF_ILA = 4'b0100,
    SLLC_MF_DATA = 4'b1000
  } sllc_link_e;
endpackage
